// ### core/tmr_pkg.sv
// constants, register map and mode type of the dual timer / event counter
package tmr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] OFF_MODE   = 4'h0;
  localparam logic [3:0] OFF_CTRL   = 4'h1;
  localparam logic [3:0] OFF_LOW0   = 4'h2;
  localparam logic [3:0] OFF_HIGH0  = 4'h3;
  localparam logic [3:0] OFF_LOW1   = 4'h4;
  localparam logic [3:0] OFF_HIGH1  = 4'h5;
  localparam logic [3:0] OFF_STATUS = 4'h6;
  localparam logic [3:0] OFF_CLEAR  = 4'h7;
  localparam logic [3:0] OFF_ENABLE = 4'h8;
  localparam logic [3:0] OFF_CONFIG = 4'h9;

  // mode_register: per channel nibble {gating_select, source_select, mode_select_high, mode_select_low}
  localparam int MODE_NIB_W  = 4;
  localparam int MODE_GATE_B = 3;
  localparam int MODE_SRC_B  = 2;
  localparam int MODE_SEL_HB = 1;

  // control_register fields: channel 0 at these, channel 1 two bits higher
  localparam int CTRL_TYPE_B = 0;
  localparam int CTRL_EXT_B  = 1;
  localparam int CTRL_RUN_B  = 4;
  localparam int CTRL_OVF_B  = 5;
  localparam int CTRL_CH_STEP = 2;

  // status / clear / enable layout
  localparam int ST_OVF0 = 0;
  localparam int ST_OVF1 = 1;
  localparam int ST_EXT0 = 2;
  localparam int ST_EXT1 = 3;
  localparam int ST_W    = 4;

  localparam int CFG_DS_B = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [4:0] PRE_TOP  = 5'h1f;

  // core clocks per peripheral cycle: standard and double speed
  localparam logic [3:0] CYC_STD = 4'hc;
  localparam logic [3:0] CYC_X2  = 4'h6;

  typedef enum logic [1:0] {MODE_13, MODE_16, MODE_RELOAD, MODE_SPLIT} mode_t;
endpackage

// ### core/chan_if.sv
// control and count signals between the register block and one channel
`timescale 1ns/1ps
interface chan_if;
  import tmr_pkg::*;
  logic        tick;
  logic        run;
  logic        alt_run;
  logic        gate;
  logic        src_sel;
  mode_t       mode;
  logic        cnt_pin;
  logic        gate_pin;
  logic        wr_low;
  logic        wr_high;
  logic [7:0]  wdata;
  logic [7:0]  low;
  logic [7:0]  high;
  logic        ovf;
  logic        alt_ovf;
  modport ctl (output tick, run, alt_run, gate, src_sel, mode, cnt_pin, gate_pin,
               output wr_low, wr_high, wdata, input low, high, ovf, alt_ovf);
  modport cnt (input tick, run, alt_run, gate, src_sel, mode, cnt_pin, gate_pin,
               input wr_low, wr_high, wdata, output low, high, ovf, alt_ovf);
endinterface

// ### core/pin_sync.sv
// two-flop synchroniser for the external pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] pins_sync
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg  <= '1;
      pins_sync <= '1;
    end else begin
      meta_reg  <= pins;
      pins_sync <= meta_reg;
    end
  end
endmodule

// ### core/count_chan.sv
// one timer / event counter channel with its two count bytes
`timescale 1ns/1ps
module count_chan #(
  parameter bit IS_CH0 = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  chan_if.cnt      ch
);
  import tmr_pkg::*;
  logic [7:0] low_reg, low_next, high_reg, high_next;
  logic       pin_prev_reg, fall, src_evt, inc, alt_inc;
  logic       ovf, alt_ovf;

  assign fall    = ch.tick & pin_prev_reg & ~ch.cnt_pin;
  assign src_evt = ch.src_sel ? fall : ch.tick;
  assign inc     = ch.run & (~ch.gate | ch.gate_pin) & src_evt;
  assign alt_inc = ch.alt_run & ch.tick;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_prev_reg <= 1'b1;
    end else if (ch.tick) begin
      pin_prev_reg <= ch.cnt_pin;
    end
  end

  always_comb begin
    low_next  = low_reg;
    high_next = high_reg;
    ovf       = 1'b0;
    alt_ovf   = 1'b0;
    case (ch.mode)
      MODE_13: begin
        if (inc) begin
          low_next[4:0] = low_reg[4:0] + 5'h01;
          if (low_reg[4:0] == PRE_TOP) begin
            high_next = high_reg + 8'h01;
            ovf       = (high_reg == ALL_ONES);
          end
        end
      end
      MODE_16: begin
        if (inc) begin
          {high_next, low_next} = {high_reg, low_reg} + 16'h0001;
          ovf = ({high_reg, low_reg} == {ALL_ONES, ALL_ONES});
        end
      end
      MODE_RELOAD: begin
        if (inc) begin
          if (low_reg == ALL_ONES) begin
            low_next = high_reg;
            ovf      = 1'b1;
          end else begin
            low_next = low_reg + 8'h01;
          end
        end
      end
      MODE_SPLIT: begin
        if (IS_CH0) begin
          if (inc) begin
            low_next = low_reg + 8'h01;
            ovf      = (low_reg == ALL_ONES);
          end
          if (alt_inc) begin
            high_next = high_reg + 8'h01;
            alt_ovf   = (high_reg == ALL_ONES);
          end
        end
      end
      default: begin
        low_next = low_reg;
      end
    endcase
    if (ch.wr_low) begin
      low_next = ch.wdata;
    end
    if (ch.wr_high) begin
      high_next = ch.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      low_reg  <= RST_BYTE;
      high_reg <= RST_BYTE;
    end else begin
      low_reg  <= low_next;
      high_reg <= high_next;
    end
  end

  assign ch.low     = low_reg;
  assign ch.high    = high_reg;
  assign ch.ovf     = ovf;
  assign ch.alt_ovf = alt_ovf;
endmodule

// ### core/dual_timer_event_counter.sv
// dual 16-bit timer / event counter with register port and interrupt
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module dual_timer_event_counter (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic [tmr_pkg::ADDR_W-1:0] addr,
  input  wire logic [tmr_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output logic      [tmr_pkg::DATA_W-1:0] rdata,
  input  wire logic                      chan0_count_pin,
  input  wire logic                      chan1_count_pin,
  input  wire logic                      external_irq0_pin_n,
  input  wire logic                      external_irq1_pin_n,
  input  wire logic [tmr_pkg::ST_W-1:0]  svc_ack,
  output logic                           irq
);
  import tmr_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  logic [7:0]      mode_reg;
  logic [7:0]      ctrl_reg, ctrl_next;
  logic [ST_W-1:0] status_reg, status_next;
  logic [ST_W-1:0] enable_reg;
  logic            ds_reg;
  logic [3:0]      div_reg;
  logic            tick;
  logic [3:0]      pins_s;
  logic [1:0]      ext_prev_reg;
  logic [1:0]      ext_set;
  logic [1:0]      ovf_set;
  logic            split;

  chan_if chn[2] ();

  // pin synchroniser: {irq1, irq0, count1, count0}
  pin_sync #(.W(4)) u_sync (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .pins      ({external_irq1_pin_n, external_irq0_pin_n, chan1_count_pin, chan0_count_pin}),
    .pins_sync (pins_s)
  );

  // peripheral cycle divider
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 4'h0;
    end else if (tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end
  assign tick = (div_reg >= ((ds_reg ? CYC_X2 : CYC_STD) - 4'h1));

  assign split = (mode_t'(mode_reg[MODE_SEL_HB:0]) == MODE_SPLIT);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      localparam int NB = gi * MODE_NIB_W;
      localparam int CB = gi * CTRL_CH_STEP;
      localparam logic [3:0] OFF_L = gi ? OFF_LOW1 : OFF_LOW0;
      localparam logic [3:0] OFF_H = gi ? OFF_HIGH1 : OFF_HIGH0;
      assign chn[gi].tick     = tick;
      assign chn[gi].mode     = mode_t'(mode_reg[NB+MODE_SEL_HB -: 2]);
      assign chn[gi].src_sel  = mode_reg[NB+MODE_SRC_B];
      assign chn[gi].cnt_pin  = pins_s[gi];
      assign chn[gi].gate_pin = pins_s[2+gi];
      assign chn[gi].wr_low   = wr_stb & hit(addr, OFF_L);
      assign chn[gi].wr_high  = wr_stb & hit(addr, OFF_H);
      assign chn[gi].wdata    = wdata;
      count_chan #(.IS_CH0(gi == 0)) u_chan (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ch       (chn[gi])
      );
    end
  endgenerate

  // channel 0 run/gate; its high byte borrows channel 1 run in split mode
  assign chn[0].run     = ctrl_reg[CTRL_RUN_B];
  assign chn[0].gate    = mode_reg[MODE_GATE_B];
  assign chn[0].alt_run = split & ctrl_reg[CTRL_RUN_B+CTRL_CH_STEP];
  // in split mode channel 1 runs freely without raising its flag
  assign chn[1].run     = split | ctrl_reg[CTRL_RUN_B+CTRL_CH_STEP];
  assign chn[1].gate    = ~split & mode_reg[MODE_NIB_W+MODE_GATE_B];
  assign chn[1].alt_run = 1'b0;

  assign ovf_set[0] = chn[0].ovf;
  assign ovf_set[1] = split ? chn[0].alt_ovf : chn[1].ovf;

  // external irq flags: falling edge when type set, low level otherwise
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_prev_reg <= 2'b11;
    end else begin
      ext_prev_reg <= pins_s[3:2];
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ext_set[i] = ctrl_reg[CTRL_TYPE_B+i*CTRL_CH_STEP] ? (ext_prev_reg[i] & ~pins_s[2+i])
                                                       : ~pins_s[2+i];
    end
  end

  // control register: software write, service clears, hardware sets win
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_stb && hit(addr, OFF_CTRL)) begin
      ctrl_next = wdata;
    end
    for (int i = 0; i < 2; i++) begin
      if (svc_ack[ST_OVF0+i]) begin
        ctrl_next[CTRL_OVF_B+i*CTRL_CH_STEP] = 1'b0;
      end
      if (svc_ack[ST_EXT0+i]) begin
        ctrl_next[CTRL_EXT_B+i*CTRL_CH_STEP] = 1'b0;
      end
      if (ovf_set[i]) begin
        ctrl_next[CTRL_OVF_B+i*CTRL_CH_STEP] = 1'b1;
      end
      if (ext_set[i]) begin
        ctrl_next[CTRL_EXT_B+i*CTRL_CH_STEP] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= RST_BYTE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= RST_BYTE;
    end else if (wr_stb && hit(addr, OFF_MODE)) begin
      mode_reg <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ds_reg <= 1'b0;
    end else if (wr_stb && hit(addr, OFF_CONFIG)) begin
      ds_reg <= wdata[CFG_DS_B];
    end
  end

  // sticky interrupt status, enable and write-one clear
  always_comb begin
    status_next = status_reg;
    if (wr_stb && hit(addr, OFF_CLEAR)) begin
      status_next = status_reg & ~wdata[ST_W-1:0];
    end
    status_next = status_next | {ext_set, ovf_set};
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= '0;
    end else if (wr_stb && hit(addr, OFF_ENABLE)) begin
      enable_reg <= wdata[ST_W-1:0];
    end
  end

  assign irq = |(status_reg & enable_reg);

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= RST_BYTE;
    end else if (!rd_stb) begin
      rdata <= RST_BYTE;
    end else begin
      case (addr)
        OFF_MODE:   rdata <= mode_reg;
        OFF_CTRL:   rdata <= ctrl_reg;
        OFF_LOW0:   rdata <= chn[0].low;
        OFF_HIGH0:  rdata <= chn[0].high;
        OFF_LOW1:   rdata <= chn[1].low;
        OFF_HIGH1:  rdata <= chn[1].high;
        OFF_STATUS: rdata <= {4'h0, status_reg};
        OFF_ENABLE: rdata <= {4'h0, enable_reg};
        OFF_CONFIG: rdata <= {7'h00, ds_reg};
        default:    rdata <= RST_BYTE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [15:0] cnt0;
  logic        quiet0;
  assign cnt0   = {chn[0].high, chn[0].low};
  assign quiet0 = !chn[0].wr_low && !chn[0].wr_high;

  chk_tick_space: assert property (tick |=> !tick [*5])
    else $error("peripheral tick spacing below six clocks");
  chk_tick_bound: assert property (tick |=> ##[5:11] tick)
    else $error("peripheral tick missing");
  chk_timer_step: assert property (chn[0].mode == MODE_16 && !chn[0].src_sel && !chn[0].gate
                                   && chn[0].run && tick && quiet0
                                   |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("timer 16-bit step wrong");
  chk_stop_hold: assert property (!chn[0].run && quiet0 |=> $stable(chn[0].low))
    else $error("low byte moved while stopped");
  chk_start_keep: assert property ($rose(chn[0].run) && !tick && quiet0 |=> $stable(cnt0))
    else $error("start altered count");
  chk_gate_block: assert property (chn[0].gate && !chn[0].gate_pin && chn[0].mode != MODE_SPLIT
                                   && quiet0 |=> $stable(chn[0].low))
    else $error("gated channel counted with pin low");
  chk_ovf_flag: assert property (ovf_set[0] |=> ctrl_reg[CTRL_OVF_B] && status_reg[ST_OVF0])
    else $error("overflow flag not set");
  chk_svc_clear: assert property (svc_ack[ST_OVF0] && !ovf_set[0] |=> !ctrl_reg[CTRL_OVF_B])
    else $error("serviced overflow flag not cleared");
  chk_reload: assert property (chn[0].mode == MODE_RELOAD && chn[0].low == ALL_ONES
                               && chn[0].ovf && quiet0
                               |=> chn[0].low == $past(chn[0].high) && $stable(chn[0].high))
    else $error("reload value wrong");
  chk_read_back: assert property (rd_stb && addr == OFF_LOW0 |=> rdata == $past(chn[0].low))
    else $error("count byte read wrong");
  chk_split_alt: assert property (split && chn[0].alt_ovf |=> ctrl_reg[CTRL_OVF_B+CTRL_CH_STEP])
    else $error("split high overflow flag missing");
  // last pin sample at a tick, kept apart from the channel's own copy
  logic pin0_prev_reg;
  logic pin0_fall;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin0_prev_reg <= 1'b1;
    end else if (tick) begin
      pin0_prev_reg <= chn[0].cnt_pin;
    end
  end
  assign pin0_fall = tick & pin0_prev_reg & ~chn[0].cnt_pin;

  chk_edge_count: assert property (chn[0].mode == MODE_16 && chn[0].src_sel && (!chn[0].run || !pin0_fall)
                                   && quiet0 |=> $stable(cnt0))
    else $error("counter moved without a sampled falling edge");
  chk_edge_step: assert property (chn[0].mode == MODE_16 && chn[0].src_sel && chn[0].run && !chn[0].gate
                                  && pin0_fall && quiet0 |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("sampled falling edge not counted");
  chk_gate_pass: assert property (chn[0].mode == MODE_16 && !chn[0].src_sel && chn[0].gate && chn[0].gate_pin
                                  && chn[0].run && tick && quiet0 |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("gated channel missed a tick with pin high");
  chk_x2_rate: assert property (tick && ds_reg |=> ##5 (tick || !ds_reg))
    else $error("double speed tick late");
  chk_prescale_top: assert property (chn[0].mode == MODE_13 && quiet0 |=> $stable(chn[0].low[7:5]))
    else $error("13-bit mode altered ignored low bits");
  chk_reload_keep: assert property (chn[0].mode == MODE_RELOAD && quiet0 |=> $stable(chn[0].high))
    else $error("reload source byte moved");
  chk_split_high: assert property (split && (!tick || !chn[0].alt_run) && quiet0 |=> $stable(chn[0].high))
    else $error("split high byte moved off tick or without run");
  chk_ch1_hold: assert property (chn[1].mode == MODE_SPLIT && !chn[1].wr_low && !chn[1].wr_high
                                 |=> $stable(chn[1].low) && $stable(chn[1].high))
    else $error("channel 1 moved in hold mode");
  chk_ovf1_flag: assert property (ovf_set[1] |=> ctrl_reg[CTRL_OVF_B+CTRL_CH_STEP] && status_reg[ST_OVF1])
    else $error("channel 1 overflow flag not set");
  chk_ext_level: assert property (!ctrl_reg[CTRL_TYPE_B] && !pins_s[2] |=> status_reg[ST_EXT0] && ctrl_reg[CTRL_EXT_B])
    else $error("external level flag not set");
  chk_status_hold: assert property (status_reg[ST_OVF0] && !(wr_stb && addr == OFF_CLEAR && wdata[ST_OVF0])
                                    |=> status_reg[ST_OVF0])
    else $error("overflow status bit lost");
  chk_read_idle: assert property (!rd_stb |=> rdata == RST_BYTE)
    else $error("read data shown without a read");
endmodule

// ### sim/pin_source.sv
// partner model: source of falling edges on one external count pin
`timescale 1ns/1ps
module pin_source #(
  parameter int HOLD = 24
) (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [3:0] n_edges,
  output logic            pin,
  output logic            busy
);
  initial begin
    pin = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        busy <= 1'b1;
        repeat (n_edges) begin
          pin <= 1'b0;
          repeat (HOLD) @(posedge core_clk);  // low level held beyond one peripheral cycle
          pin <= 1'b1;
          repeat (HOLD) @(posedge core_clk);  // high level held as long
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ### sim/dual_timer_event_counter_tb.sv
// self-checking bench for the dual timer / event counter
`timescale 1ns/1ps
module dual_timer_event_counter_tb;
  import tmr_pkg::*;
  logic              core_clk;
  logic              nrst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_stb;
  logic              rd_stb;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        cpin;
  logic [1:0]        gpin_n;
  logic [ST_W-1:0]   svc_ack;
  logic              irq;
  logic [1:0]        go;
  logic [1:0]        busy;
  logic [3:0]        n0;
  logic [3:0]        n1;
  logic [7:0]        v;
  int                error_cnt;
  int                n_tests;
  int                m_lo;
  int                m_hi;
  int                m_ovf;
  int                e0;
  int                e1;
  int                lim;
  int                s0;

  dual_timer_event_counter i_dual_timer_event_counter (
    .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .chan0_count_pin(cpin[0]), .chan1_count_pin(cpin[1]), .external_irq0_pin_n(gpin_n[0]),
    .external_irq1_pin_n(gpin_n[1]), .svc_ack(svc_ack), .irq(irq));
  pin_source i_pin_source0 (.core_clk(core_clk), .go(go[0]), .n_edges(n0), .pin(cpin[0]), .busy(busy[0]));
  pin_source i_pin_source1 (.core_clk(core_clk), .go(go[1]), .n_edges(n1), .pin(cpin[1]), .busy(busy[1]));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic chk_rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
    chk(what, exp, v);
  endtask

  task automatic chk_irq(input logic e);
    #1;
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask

  // model: one count event of channel 0 in the given mode
  task automatic step(input int m);
    int t;
    int w;
    w = (m == 0) ? 13 : (m == 1) ? 16 : 8;
    t = (m == 0) ? m_hi * 32 + m_lo % 32 : (m == 1) ? m_hi * 256 + m_lo : (m == 2) ? m_lo : m_hi;
    t = t + 1;
    if (t == (1 << w)) m_ovf = 1;
    if (m == 0) m_lo = (m_lo / 32) * 32 + t % 32;
    if (m == 0) m_hi = (t / 32) % 256;
    if (m == 1) m_lo = t % 256;
    if (m == 1) m_hi = (t / 256) % 256;
    if (m == 2) m_lo = (t == 256) ? m_hi : t;
    if (m == 3) m_hi = t % 256;
  endtask

  // reads one byte every cycle until three changes from the preset are seen, then stops the channel at once
  task automatic poll(input logic [3:0] a, input int per, input logic [7:0] start, input logic [7:0] stop_val);
    logic [7:0] last;
    int         seen;
    int         gap;
    seen = 0;
    gap = 0;
    lim = 0;
    last = start;
    @(posedge core_clk);
    rd_stb <= 1'b1;
    addr <= a;
    while (seen < 3 && lim < 200) begin
      @(posedge core_clk);
      #1;
      gap++;
      lim++;
      if (rdata !== last) begin
        if (seen > 0) chk("tick spacing", 8'(per), 8'(gap));
        seen++;
        gap = 0;
        last = rdata;
      end
    end
    chk("count changes", 8'h03, 8'(seen));
    @(posedge core_clk);
    rd_stb <= 1'b0;
    wr_stb <= 1'b1;
    addr <= OFF_CTRL;
    wdata <= stop_val;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    n_tests = 0;
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    gpin_n = 2'b11;
    svc_ack = '0;
    go = 2'b00;
    n0 = '0;
    n1 = '0;
    void'($urandom(50555));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 11; a++) chk_rd("reset value", 4'(a), 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 8'h00);  // stopped before retuning
      wr(OFF_CONFIG, {7'h0, m[0]});
      wr(OFF_MODE, 8'(m));
      chk_rd("mode", OFF_MODE, 8'(m));
      m_lo = (m == 0) ? $urandom_range(7, 0) * 32 + 30 : 254;
      m_hi = (m == 2) ? $urandom_range(253, 0) : (m == 3) ? 254 : 255;
      m_ovf = 0;
      wr(OFF_LOW0, 8'(m_lo));  // preset only while stopped
      wr(OFF_HIGH0, 8'(m_hi));
      wr(OFF_CLEAR, 8'h0f);
      wr(OFF_CTRL, (m == 3) ? 8'h40 : 8'h10);
      s0 = (m == 3) ? m_hi : m_lo;
      for (int i = 0; i < 3; i++) step(m);
      poll((m == 3) ? OFF_HIGH0 : OFF_LOW0, m[0] ? 6 : 12, 8'(s0),
           8'(m_ovf << ((m == 3) ? 7 : 5)));
      chk_rd("low0", OFF_LOW0, 8'(m_lo));
      chk_rd("high0", OFF_HIGH0, 8'(m_hi));
      chk_rd("ctrl", OFF_CTRL, 8'(m_ovf << ((m == 3) ? 7 : 5)));
      chk_rd("status", OFF_STATUS, 8'(m_ovf << ((m == 3) ? 1 : 0)));
      if (m == 1) begin
        wr(OFF_ENABLE, 8'h00);
        chk_irq(1'b0);
        wr(OFF_STATUS, 8'h00);
        chk_rd("status read only", OFF_STATUS, 8'h01);
        wr(OFF_ENABLE, 8'h01);
        chk_irq(1'b1);
        @(posedge core_clk);
        svc_ack <= 4'h1;
        @(posedge core_clk);
        svc_ack <= 4'h0;
        chk_rd("ctrl serviced", OFF_CTRL, 8'h00);
        wr(OFF_CLEAR, 8'h01);
        chk_irq(1'b0);
      end
    end
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CONFIG, 8'h00);
    wr(OFF_MODE, 8'hdd);
    for (int r = 0; r < 2; r++) begin
      wr(OFF_CTRL, 8'h01);
      wr(OFF_CLEAR, 8'h0f);
      for (int b = 2; b < 6; b++) wr(4'(b), 8'h00);  // preset while stopped
      @(posedge core_clk);
      gpin_n <= 2'(r * 3);
      e0 = $urandom_range(6, 1);
      e1 = $urandom_range(6, 1);
      n0 <= 4'(e0);
      n1 <= 4'(e1);
      repeat (8) @(posedge core_clk);
      wr(OFF_CTRL, 8'h51);
      @(posedge core_clk);
      go <= 2'b11;
      @(posedge core_clk);
      go <= 2'b00;
      lim = 0;
      repeat (2) @(posedge core_clk);
      while (busy !== 2'b00 && lim < 2000) begin
        @(posedge core_clk);
        lim++;
      end
      repeat (40) @(posedge core_clk);
      wr(OFF_CTRL, 8'h01);
      chk_rd("pin count 0", OFF_LOW0, 8'(r * e0));
      chk_rd("pin count 1", OFF_LOW1, 8'(r * e1));
      chk_rd("ext flags", OFF_STATUS, r ? 8'h08 : 8'h0c);
    end
    wrap_up();
  end
endmodule
